// >>> hw/lhp_cfg.svh
// register offsets, field positions, reset values and serial frame counts
// of the line interface host control port.
// assumes nothing beyond being included once per compilation unit.
`ifndef LHP_CFG_SVH
`define LHP_CFG_SVH

// register offsets
`define LHP_ADDR_GLOBAL_CONFIG 8'h02
`define LHP_ADDR_INT_MASK_0 8'h14
`define LHP_ADDR_INT_MASK_1 8'h15
`define LHP_ADDR_INT_STATUS_0 8'h19
`define LHP_ADDR_INT_STATUS_1 8'h1A

// reset values and the read value of unmapped offsets
`define LHP_RST_GLOBAL_CONFIG 8'h00
`define LHP_RST_INT_MASK 8'hFF
`define LHP_RST_INT_STATUS 8'h00
`define LHP_RD_UNMAPPED 8'h00

// global_config fields
`define LHP_GCF_INTPIN_MSB 1
`define LHP_GCF_INTPIN_LSB 0
`define LHP_GCF_INBAND_BIT 7

// interrupt pin styles
`define LHP_INTPIN_PP_LOW 2'h0
`define LHP_INTPIN_PP_HIGH 2'h1
`define LHP_INTPIN_OD_LOW 2'h2
`define LHP_INTPIN_OD_LOW_ALT 2'h3

// control mode pin codes
`define LHP_MODE_HARDWARE 2'h0
`define LHP_MODE_SERIAL 2'h1
`define LHP_MODE_DIRSTYLE 2'h2
`define LHP_MODE_STROBE 2'h3

// hardware loopback codes
`define LHP_LB_NONE 2'h0
`define LHP_LB_ANALOG 2'h1
`define LHP_LB_DIGITAL 2'h2
`define LHP_LB_REMOTE 2'h3

// serial frame: count of rising shift edges already seen before the edge
`define LHP_SER_CNT_RW 5'h00
`define LHP_SER_CNT_ADDR_LAST 5'h08
`define LHP_SER_CNT_TURN 5'h09
`define LHP_SER_CNT_DATA_LAST 5'h11
`define LHP_SER_CNT_STOP 5'h12

`endif

// >>> hw/lhp_pkg.sv
// types of the line interface host control port: bus state machine and
// the state records of the system clock and shift clock domains.
// assumes lhp_cfg.svh for all numeric constants.
package lhp_pkg;

   typedef enum logic [2:0] {
      P_IDLE = 3'b001,
      P_BUSY = 3'b010,
      P_DONE = 3'b100
   } lhp_pstate_e;

   typedef struct packed {
      lhp_pstate_e pst;
      logic pread;
      logic [7:0] paddr;
      logic [7:0] global_config;
      logic [7:0] msk0;
      logic [7:0] msk1;
      logic [7:0] sts0;
      logic [7:0] sts1;
      logic [7:0] ad_out;
      logic ad_oe;
      logic ack_rdy;
      logic [7:0] sdata;
      logic irq_out;
      logic irq_oe;
      logic lb_analog;
      logic lb_digital;
      logic lb_remote;
      logic lb_inband;
      logic term_int;
      logic ale_prev;
      logic [1:0] tgl_prev;
      logic link_rst;
   } lhp_sys_s;

   // survives chip select, cleared only by the link reset
   typedef struct packed {
      logic rw;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr_tgl;
      logic rd_tgl;
   } lhp_link_s;

   // cleared while chip select is high
   typedef struct packed {
      logic [4:0] cnt;
      logic oe;
      logic rise_out;
      logic [7:0] shout;
   } lhp_frame_s;

endpackage

// >>> hw/lhp_sync.sv
// two flip-flop synchroniser for a group of independent levels.
// assumes each bit is a quasi-static level or is held by its source
// long enough to be seen; bits are not guaranteed to arrive together.
`timescale 1ns/100ps
module lhp_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// >>> hw/lhp_top.sv
// host control port of the line interface: serial shift port, the two
// multiplexed parallel bus styles, interrupt registers and request pin,
// and the hardware-mode loopback and termination pin decode.
// assumes pins are asynchronous to sys_clk; serial_clk only runs in frames.
`include "lhp_cfg.svh"
`timescale 1ns/100ps
module lhp_top (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [1:0] ctrl_mode,
   input wire logic chip_select_n,
   input wire logic serial_clk,
   input wire logic serial_in,
   input wire logic shift_edge_select,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe,
   input wire logic addr_latch_strobe,
   input wire logic data_strobe_n,
   input wire logic write_ctl,
   output logic ack_rdy,
   input wire logic [15:0] irq_events,
   output logic irq_out,
   output logic irq_oe,
   input wire logic [1:0] loopback_select,
   input wire logic term_select,
   output logic lb_analog,
   output logic lb_digital,
   output logic lb_remote,
   output logic lb_inband,
   output logic term_internal
);
   localparam int PW = 18;
   localparam lhp_pkg::lhp_sys_s SYS_RST = '{
      pst: lhp_pkg::P_IDLE,
      global_config: `LHP_RST_GLOBAL_CONFIG,
      msk0: `LHP_RST_INT_MASK,
      msk1: `LHP_RST_INT_MASK,
      sts0: `LHP_RST_INT_STATUS,
      sts1: `LHP_RST_INT_STATUS,
      ack_rdy: 1'b1,
      link_rst: 1'b1,
      default: '0
   };

   lhp_pkg::lhp_sys_s sq, sd;
   lhp_pkg::lhp_link_s lq, ld;
   lhp_pkg::lhp_frame_s fq, fd;
   logic fall_out_q;
   logic frame_clr;

   logic [PW-1:0] pin_raw, pin_s;
   logic [1:0] tgl_raw, tgl_s;
   logic cs_n_s, ale_s, ds_s, wc_s, term_s, edge_s;
   logic [1:0] mode_s, lp_s;
   logic [7:0] ad_s;

   logic sw_mode, ser_mode, dir_mode, stb_mode;
   logic strobe_on, is_read, pending;
   logic we, re;
   logic [7:0] wa, wd, ra, clr0, clr1;

   assign pin_raw = {chip_select_n, ctrl_mode, addr_latch_strobe, data_strobe_n, write_ctl,
                     ad_in, loopback_select, term_select, shift_edge_select};
   assign cs_n_s = pin_s[17];
   assign mode_s = pin_s[16:15];
   assign ale_s = pin_s[14];
   assign ds_s = pin_s[13];
   assign wc_s = pin_s[12];
   assign ad_s = pin_s[11:4];
   assign lp_s = pin_s[3:2];
   assign term_s = pin_s[1];
   assign edge_s = pin_s[0];
   assign tgl_raw = {lq.wr_tgl, lq.rd_tgl};

   lhp_sync #(.W(PW)) u_pin_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .d(pin_raw),
      .q(pin_s)
   );

   // serial requests cross as toggles; address and data are held still by the frame
   lhp_sync #(.W(2)) u_tgl_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .d(tgl_raw),
      .q(tgl_s)
   );

   function automatic logic [7:0] reg_rd(input logic [7:0] a, input lhp_pkg::lhp_sys_s s);
      logic [7:0] v;
      v = `LHP_RD_UNMAPPED;
      if (a == `LHP_ADDR_GLOBAL_CONFIG)
      begin
         v = s.global_config;
      end
      else if (a == `LHP_ADDR_INT_MASK_0)
      begin
         v = s.msk0;
      end
      else if (a == `LHP_ADDR_INT_MASK_1)
      begin
         v = s.msk1;
      end
      else if (a == `LHP_ADDR_INT_STATUS_0)
      begin
         v = s.sts0;
      end
      else if (a == `LHP_ADDR_INT_STATUS_1)
      begin
         v = s.sts1;
      end
      return v;
   endfunction

   always_comb
   begin
      sd = sq;
      we = 1'b0;
      re = 1'b0;
      wa = 8'h00;
      wd = 8'h00;
      ra = 8'h00;
      clr0 = 8'h00;
      clr1 = 8'h00;
      sd.link_rst = 1'b0;
      sd.ale_prev = ale_s;
      sd.tgl_prev = tgl_s;
      sw_mode = (mode_s != `LHP_MODE_HARDWARE);
      ser_mode = (mode_s == `LHP_MODE_SERIAL);
      dir_mode = (mode_s == `LHP_MODE_DIRSTYLE);
      stb_mode = (mode_s == `LHP_MODE_STROBE);
      // strobe style: either strobe low; direction style: data strobe low
      strobe_on = stb_mode ? (!ds_s || !wc_s) : !ds_s;
      is_read = stb_mode ? !ds_s : wc_s;

      if (ser_mode && (tgl_s[1] != sq.tgl_prev[1]))
      begin
         we = 1'b1;
         wa = lq.addr;
         wd = lq.wdata;
      end
      if (ser_mode && (tgl_s[0] != sq.tgl_prev[0]))
      begin
         re = 1'b1;
         ra = lq.addr;
         sd.sdata = reg_rd(lq.addr, sq);
      end

      if (cs_n_s || !(dir_mode || stb_mode))
      begin
         sd.pst = lhp_pkg::P_IDLE;
         sd.ad_oe = 1'b0;
         sd.ack_rdy = 1'b1;
      end
      else
      begin
         // one pin serves as latch enable or address strobe
         if (sq.ale_prev && !ale_s)
         begin
            sd.paddr = ad_s;
         end
         case (sq.pst)
            lhp_pkg::P_IDLE:
            begin
               if (strobe_on)
               begin
                  sd.pst = lhp_pkg::P_BUSY;
                  sd.pread = is_read;
                  sd.ack_rdy = !stb_mode;
               end
            end
            lhp_pkg::P_BUSY:
            begin
               if (sq.pread)
               begin
                  re = 1'b1;
                  ra = sq.paddr;
                  sd.ad_out = reg_rd(sq.paddr, sq);
                  sd.ad_oe = 1'b1;
               end
               else
               begin
                  we = 1'b1;
                  wa = sq.paddr;
                  wd = ad_s;
               end
               sd.pst = lhp_pkg::P_DONE;
               sd.ack_rdy = stb_mode;
            end
            lhp_pkg::P_DONE:
            begin
               if (!strobe_on)
               begin
                  sd.pst = lhp_pkg::P_IDLE;
                  sd.ad_oe = 1'b0;
                  sd.ack_rdy = 1'b1;
               end
            end
            default:
            begin
               sd.pst = lhp_pkg::P_IDLE;
               sd.ad_oe = 1'b0;
               sd.ack_rdy = 1'b1;
            end
         endcase
      end

      // status clears on read, but an event in the same cycle stays set
      if (re && (ra == `LHP_ADDR_INT_STATUS_0))
      begin
         clr0 = 8'hFF;
      end
      else if (re && (ra == `LHP_ADDR_INT_STATUS_1))
      begin
         clr1 = 8'hFF;
      end
      sd.sts0 = (sq.sts0 & ~clr0) | irq_events[7:0];
      sd.sts1 = (sq.sts1 & ~clr1) | irq_events[15:8];

      if (we && (wa == `LHP_ADDR_GLOBAL_CONFIG))
      begin
         sd.global_config = wd;
      end
      else if (we && (wa == `LHP_ADDR_INT_MASK_0))
      begin
         sd.msk0 = wd;
      end
      else if (we && (wa == `LHP_ADDR_INT_MASK_1))
      begin
         sd.msk1 = wd;
      end

      // mask bit set means the source is kept off the pin
      pending = |(sq.sts0 & ~sq.msk0) || |(sq.sts1 & ~sq.msk1);
      if (!sw_mode)
      begin
         sd.irq_out = 1'b0;
         sd.irq_oe = 1'b0;
      end
      else
      begin
         case (sq.global_config[`LHP_GCF_INTPIN_MSB:`LHP_GCF_INTPIN_LSB])
            `LHP_INTPIN_PP_LOW:
            begin
               sd.irq_out = !pending;
               sd.irq_oe = 1'b1;
            end
            `LHP_INTPIN_PP_HIGH:
            begin
               sd.irq_out = pending;
               sd.irq_oe = 1'b1;
            end
            default:
            begin
               sd.irq_out = 1'b0;
               sd.irq_oe = pending;
            end
         endcase
      end

      // register-side analog, digital and remote loopback and termination live outside this block; in-band comes from global_config
      if (!sw_mode)
      begin
         sd.lb_analog = (lp_s == `LHP_LB_ANALOG);
         sd.lb_digital = (lp_s == `LHP_LB_DIGITAL);
         sd.lb_remote = (lp_s == `LHP_LB_REMOTE);
         sd.lb_inband = 1'b0;
         sd.term_int = term_s;
      end
      else
      begin
         sd.lb_analog = 1'b0;
         sd.lb_digital = 1'b0;
         sd.lb_remote = 1'b0;
         sd.lb_inband = sq.global_config[`LHP_GCF_INBAND_BIT];
         sd.term_int = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sq <= SYS_RST;
      end
      else
      begin
         sq <= sd;
      end
   end

   // shift clock domain; the frame part is held clear while chip select is high
   assign frame_clr = chip_select_n | sq.link_rst;

   always_comb
   begin
      ld = lq;
      fd = fq;
      if (fq.cnt != `LHP_SER_CNT_STOP)
      begin
         fd.cnt = fq.cnt + 5'h01;
      end
      if (fq.cnt == `LHP_SER_CNT_RW)
      begin
         ld.rw = serial_in;
      end
      else if (fq.cnt <= `LHP_SER_CNT_ADDR_LAST)
      begin
         ld.addr = {lq.addr[6:0], serial_in};
         if ((fq.cnt == `LHP_SER_CNT_ADDR_LAST) && lq.rw)
         begin
            ld.rd_tgl = !lq.rd_tgl;
         end
      end
      else if (fq.cnt == `LHP_SER_CNT_TURN)
      begin
         // read data was fetched during the host's pause before this edge
         if (lq.rw)
         begin
            fd.shout = sq.sdata;
            fd.oe = 1'b1;
         end
      end
      else if (fq.cnt <= `LHP_SER_CNT_DATA_LAST)
      begin
         if (lq.rw)
         begin
            fd.rise_out = fq.shout[7];
            fd.shout = {fq.shout[6:0], 1'b0};
         end
         else
         begin
            ld.wdata = {lq.wdata[6:0], serial_in};
            if (fq.cnt == `LHP_SER_CNT_DATA_LAST)
            begin
               ld.wr_tgl = !lq.wr_tgl;
            end
         end
      end
      // edges while deselected leave the link record alone
      if (chip_select_n)
      begin
         ld = lq;
      end
   end

   always_ff @(posedge serial_clk or posedge sq.link_rst)
   begin
      if (sq.link_rst)
      begin
         lq <= '0;
      end
      else
      begin
         lq <= ld;
      end
   end

   always_ff @(posedge serial_clk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         fq <= '0;
      end
      else
      begin
         fq <= fd;
      end
   end

   always_ff @(negedge serial_clk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         fall_out_q <= 1'b0;
      end
      else
      begin
         fall_out_q <= fq.shout[7];
      end
   end

   // edge select is a strap; its synchronised copy only steers this mux
   assign serial_out = edge_s ? fall_out_q : fq.rise_out;
   assign serial_out_oe = fq.oe;

   assign ad_out = sq.ad_out;
   assign ad_oe = sq.ad_oe;
   assign ack_rdy = sq.ack_rdy;
   assign irq_out = sq.irq_out;
   assign irq_oe = sq.irq_oe;
   assign lb_analog = sq.lb_analog;
   assign lb_digital = sq.lb_digital;
   assign lb_remote = sq.lb_remote;
   assign lb_inband = sq.lb_inband;
   assign term_internal = sq.term_int;
endmodule

// >>> test/lhp_chk.sv
// checker for the host control port, bound to lhp_top.
// assumes pins held steady for several sys_clk cycles around each change.
`timescale 1ns/100ps
module lhp_chk (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [1:0] ctrl_mode,
   input wire logic chip_select_n,
   input wire logic data_strobe_n,
   input wire logic write_ctl,
   input wire logic [1:0] loopback_select,
   input wire logic term_select,
   input wire logic ad_oe,
   input wire logic ack_rdy,
   input wire logic irq_oe,
   input wire logic serial_out_oe,
   input wire logic lb_analog,
   input wire logic lb_remote,
   input wire logic lb_inband,
   input wire logic term_internal
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   // five cycles cover two synchroniser stages plus the output register
   a_lb_decode: assert property ((ctrl_mode == 2'h0 && loopback_select == 2'h1)[*5]
      |-> lb_analog && !lb_remote) else $error("loopback decode wrong");
   a_sw_lb_off: assert property ((ctrl_mode != 2'h0)[*5]
      |-> !lb_analog && !lb_remote && !term_internal) else $error("pin decode active");
   a_hw_no_inband: assert property ((ctrl_mode == 2'h0)[*5]
      |-> !lb_inband && !irq_oe) else $error("inband or irq in pin mode");
   a_term_pick: assert property ((ctrl_mode == 2'h0 && term_select)[*5]
      |-> term_internal) else $error("termination not internal");
   a_rdy_busy: assert property (ctrl_mode == 2'h3 && $fell(ack_rdy)
      |=> ack_rdy) else $error("ready stuck low");
   a_dir_ack: assert property (ctrl_mode == 2'h2 && $fell(ack_rdy)
      |-> ad_oe == write_ctl) else $error("ack without matching bus drive");
   a_ack_cause: assert property ($fell(ack_rdy) |-> !chip_select_n)
      else $error("answer while deselected");
   a_read_only: assert property ((ctrl_mode == 2'h3 && data_strobe_n)[*5]
      |-> !ad_oe) else $error("bus driven outside read");
   a_cs_quiet: assert property (chip_select_n[*5] |-> !ad_oe && ack_rdy)
      else $error("bus active while deselected");
   c_rdy: cover property (ctrl_mode == 2'h3 && $fell(ack_rdy));
   c_ack: cover property (ctrl_mode == 2'h2 && $fell(ack_rdy));
   c_ser: cover property ($rose(serial_out_oe));
endmodule

bind lhp_top lhp_chk i_chk (.sys_clk(sys_clk), .srst(srst), .ctrl_mode(ctrl_mode),
   .chip_select_n(chip_select_n), .data_strobe_n(data_strobe_n), .write_ctl(write_ctl),
   .loopback_select(loopback_select), .term_select(term_select), .ad_oe(ad_oe),
   .ack_rdy(ack_rdy), .irq_oe(irq_oe), .serial_out_oe(serial_out_oe),
   .lb_analog(lb_analog), .lb_remote(lb_remote), .lb_inband(lb_inband),
   .term_internal(term_internal));

// >>> test/lhp_host.sv
// host model: multiplexed parallel bus in both styles and the serial frame.
// assumes the bench picks the mode; a released bus shows a changed pattern.
`timescale 1ns/100ps
module lhp_host (
   input wire logic sys_clk,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe,
   input wire logic ack_rdy,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic shift_edge_select,
   output logic chip_select_n = 1'b1,
   output logic serial_clk = 1'b0,
   output logic serial_in = 1'b0,
   output logic [7:0] ad_in,
   output logic addr_latch_strobe = 1'b0,
   output logic data_strobe_n = 1'b1,
   output logic write_ctl = 1'b1
);
   logic [7:0] drv_q = 8'h00;
   logic drv_oe = 1'b0;
   assign ad_in = ad_oe ? ad_out : (drv_oe ? drv_q : ~drv_q);

   task automatic par(input logic dir, input logic rd, input logic cs_n, input logic [7:0] a,
      input logic [7:0] wd, output logic [7:0] rdata, output logic seen);
      int n;
      n = 0;
      seen = 1'b0;
      @(posedge sys_clk);
      chip_select_n <= cs_n;
      addr_latch_strobe <= 1'b1;
      drv_q <= a;
      drv_oe <= 1'b1;
      write_ctl <= dir ? rd : 1'b1;
      repeat (3) @(posedge sys_clk);
      addr_latch_strobe <= 1'b0;
      repeat (4) @(posedge sys_clk);
      drv_q <= wd;
      drv_oe <= !rd;
      data_strobe_n <= !(dir || rd);
      if (!dir && !rd) write_ctl <= 1'b0;
      do
      begin
         @(posedge sys_clk);
         n++;
         if (!ack_rdy) seen = 1'b1;
      end
      while (n < 12 && !(dir ? !ack_rdy : seen && ack_rdy));
      rdata = ad_out;
      data_strobe_n <= 1'b1;
      write_ctl <= 1'b1;
      drv_oe <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chip_select_n <= 1'b1;
      @(posedge sys_clk);
   endtask

   task automatic ser(input logic rd, input logic [7:0] a, input logic [7:0] wd,
      output logic [7:0] rdata, output logic oe_seen);
      logic [17:0] bits;
      bits = {rd, a, 1'b0, wd};
      rdata = 8'h00;
      oe_seen = 1'b0;
      chip_select_n <= 1'b0;
      #200;
      for (int i = 0; i < 18; i++)
      begin
         serial_in = bits[17 - i];
         #16;
         serial_clk = 1'b1;
         if (i >= 10 && shift_edge_select) rdata = {rdata[6:0], serial_out};
         #16;
         serial_clk = 1'b0;
         if (i >= 10 && !shift_edge_select) rdata = {rdata[6:0], serial_out};
         if (i == 10) oe_seen = serial_out_oe;
         // read data is fetched across the clock boundary during this pause
         if (i == 8) #700;
      end
      #100;
      chip_select_n <= 1'b1;
      serial_in = ~serial_in;
      #500;
   endtask
endmodule

// >>> test/tb.sv
// self-checking bench for lhp_top with the host model on its bus pins.
// assumes register offsets, reset values and codes from lhp_cfg.svh.
`include "lhp_cfg.svh"
`timescale 1ns/100ps
module tb;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] ctrl_mode = `LHP_MODE_STROBE;
   logic shift_edge_select = 1'b0;
   logic [15:0] irq_events = 16'h0000;
   logic [1:0] loopback_select = 2'h0;
   logic term_select = 1'b0;
   logic chip_select_n, serial_clk, serial_in, addr_latch_strobe, data_strobe_n, write_ctl;
   logic serial_out, serial_out_oe, ad_oe, ack_rdy, irq_out, irq_oe, flag;
   logic lb_analog, lb_digital, lb_remote, lb_inband, term_internal;
   logic [7:0] ad_in, ad_out, rd_v;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;

   lhp_top i_dut (.sys_clk(sys_clk), .srst(srst), .ctrl_mode(ctrl_mode),
      .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
      .shift_edge_select(shift_edge_select), .serial_out(serial_out),
      .serial_out_oe(serial_out_oe), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .addr_latch_strobe(addr_latch_strobe), .data_strobe_n(data_strobe_n),
      .write_ctl(write_ctl), .ack_rdy(ack_rdy), .irq_events(irq_events), .irq_out(irq_out),
      .irq_oe(irq_oe), .loopback_select(loopback_select), .term_select(term_select),
      .lb_analog(lb_analog), .lb_digital(lb_digital), .lb_remote(lb_remote),
      .lb_inband(lb_inband), .term_internal(term_internal));
   lhp_host i_host (.sys_clk(sys_clk), .ad_out(ad_out), .ad_oe(ad_oe), .ack_rdy(ack_rdy),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .shift_edge_select(shift_edge_select), .chip_select_n(chip_select_n),
      .serial_clk(serial_clk), .serial_in(serial_in), .ad_in(ad_in),
      .addr_latch_strobe(addr_latch_strobe), .data_strobe_n(data_strobe_n),
      .write_ctl(write_ctl));

   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic complete_run;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         err_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.par(ctrl_mode == `LHP_MODE_DIRSTYLE, 1'b0, 1'b0, a, d, rd_v, flag);
      chk(flag, 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_host.par(ctrl_mode == `LHP_MODE_DIRSTYLE, 1'b1, 1'b0, a, 8'h00, rd_v, flag);
      chk(rd_v, exp);
   endtask

   task automatic set_mode(input logic [1:0] m);
      @(posedge sys_clk);
      ctrl_mode <= m;
      repeat (6) @(posedge sys_clk);
   endtask

   task automatic t_regs;
      rd(`LHP_ADDR_GLOBAL_CONFIG, `LHP_RST_GLOBAL_CONFIG);
      rd(`LHP_ADDR_INT_MASK_0, `LHP_RST_INT_MASK);
      rd(`LHP_ADDR_INT_MASK_1, `LHP_RST_INT_MASK);
      rd(`LHP_ADDR_INT_STATUS_1, `LHP_RST_INT_STATUS);
      rd(8'h03, `LHP_RD_UNMAPPED);
      wr(`LHP_ADDR_INT_STATUS_0, 8'hFF);
      rd(`LHP_ADDR_INT_STATUS_0, `LHP_RST_INT_STATUS);
      wr(`LHP_ADDR_GLOBAL_CONFIG, 8'h80);
      chk(lb_inband, 1'b1);
      $display("regs done");
   endtask

   task automatic t_dir;
      set_mode(`LHP_MODE_DIRSTYLE);
      wr(`LHP_ADDR_INT_MASK_1, 8'h3C);
      rd(`LHP_ADDR_INT_MASK_1, 8'h3C);
      // deselected access must leave the answer line alone; the register is rewritten before any read-back
      i_host.par(1'b1, 1'b0, 1'b1, `LHP_ADDR_INT_MASK_1, 8'hFF, rd_v, flag);
      chk(flag, 1'b0);
      wr(`LHP_ADDR_INT_MASK_1, `LHP_RST_INT_MASK);
      rd(`LHP_ADDR_INT_MASK_1, `LHP_RST_INT_MASK);
      set_mode(`LHP_MODE_STROBE);
      $display("dir done");
   endtask

   task automatic t_irq;
      wr(`LHP_ADDR_INT_MASK_0, 8'hF7);
      for (int s = 0; s < 4; s++)
      begin
         wr(`LHP_ADDR_GLOBAL_CONFIG, 8'h80 | 8'(s));
         @(posedge sys_clk);
         irq_events <= 16'h0208;
         @(posedge sys_clk);
         irq_events <= 16'h0000;
         repeat (3) @(posedge sys_clk);
         chk({irq_oe, irq_out}, {7'h01, s == 1});
         rd(`LHP_ADDR_INT_STATUS_0, 8'h08);
         rd(`LHP_ADDR_INT_STATUS_0, 8'h00);
         // only the masked source of the second status register is still set here
         chk({irq_oe, irq_out}, s == 0 ? 8'h03 : s == 1 ? 8'h02 : 8'h00);
         rd(`LHP_ADDR_INT_STATUS_1, 8'h02);
      end
      $display("irq done");
   endtask

   task automatic t_ser;
      set_mode(`LHP_MODE_SERIAL);
      for (int e = 0; e < 2; e++)
      begin
         shift_edge_select <= e[0];
         repeat (6) @(posedge sys_clk);
         i_host.ser(1'b0, `LHP_ADDR_INT_MASK_0, 8'h5C ^ 8'(e), rd_v, flag);
         chk(flag, 1'b0);
         i_host.ser(1'b1, `LHP_ADDR_INT_MASK_0, 8'h00, rd_v, flag);
         chk(rd_v, 8'h5C ^ 8'(e));
         chk(flag, 1'b1);
      end
      $display("serial done");
   endtask

   task automatic t_hw;
      set_mode(`LHP_MODE_HARDWARE);
      for (int i = 0; i < 8; i++)
      begin
         loopback_select <= i[1:0];
         term_select <= i[2];
         repeat (6) @(posedge sys_clk);
         chk({lb_remote, lb_digital, lb_analog, lb_inband, term_internal},
            {i[1:0] == 2'h3, i[1:0] == 2'h2, i[1:0] == 2'h1, 1'b0, i[2]});
      end
      $display("hardware done");
   endtask

   initial
   begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_regs();
      t_dir();
      t_irq();
      t_ser();
      t_hw();
      complete_run();
   end
endmodule
